/* logic/wwd_regs.vh */
// Register map, field positions, reset values and codes of the window watchdog
`ifndef WWD_REGS_VH
`define WWD_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define WWD_IDX_TIMEOUT_CTRL   12'hed2
`define WWD_IDX_CLK_WIN_CTRL   12'hed3
`define WWD_IDX_PS_LOW         12'hed4
`define WWD_IDX_PS_HIGH        12'hed5
`define WWD_IDX_WIN_STATUS     12'hed6
`define WWD_IDX_WIDTH          12
`define WWD_ADDR_WIDTH         14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WWD_PS_SEL_LSB         1
`define WWD_PS_SEL_MSB         5
`define WWD_CLK_SEL_LSB        4
`define WWD_CLK_SEL_MSB        6
`define WWD_WIN_LSB            0
`define WWD_WIN_MSB            2
`define WWD_WINCNT_LSB         3
`define WWD_ARMED_BIT          2

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define WWD_CFG_ALL_ONES_5     5'h1f
`define WWD_CFG_ALL_ONES_3     3'h7
`define WWD_PS_DEFAULT         5'h0b
`define WWD_CLK_DEFAULT        3'h0
`define WWD_CLK_LFOSC          3'h0
`define WWD_CLK_MFOSC          3'h1
`define WWD_WIN_FULL_OPEN      3'h7
`define WWD_PS_MAX_CODE        5'h12
`define WWD_PS_RESET           8'h00
`define WWD_TMR_RESET          8'h00
`define WWD_CNT_WIDTH          23
`define WWD_PS_WIDTH           18

`endif

/* logic/wwd_window_regs.v */
// Window watchdog: clock/window control, prescale and window counter, arming
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/10ps
`include "wwd_regs.vh"
//
// Behaviour
// - Factory timeout all ones: prescale resets to 2s code
// - Otherwise prescale select resets to factory timeout value
// - Prescale select read-only unless factory timeout all ones
// - Clock select 000 low-freq, 001 medium-freq oscillator
// - Clock select resets 000 or factory clock value
// - Clock select read-only unless factory clock cfg 111
// - Window size resets from factory window value
// - Window size read-only unless factory window cfg 111
// - Window code sets closed delay, 12.5 percent steps
// - 18-bit prescale count over low, high, timer bits
// - Prescale high byte read-only, resets zero
// - Prescale low byte read-only, resets zero
// - Window counter in timer bits 7:3, resets zero
// - Closed below four times seven minus window code
// - Timer bit 2 shows armed state
// - Timer register read-only, resets all zero
// - Windowed clear needs prior timeout control read arm
// - Clear while window closed causes watchdog reset
module wwd_window_regs (
  // Clock and reset
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  // Factory configuration fields
  input  wire [4:0]  i_factory_timeout_cfg,
  input  wire [2:0]  i_factory_clock_cfg,
  input  wire [2:0]  i_factory_window_cfg,
  // Oscillator ticks and watchdog control
  input  wire        i_low_freq_osc_tick,
  input  wire        i_med_freq_osc_tick,
  input  wire        i_wdt_enable,
  input  wire        i_watchdog_clear_instr,
  // Avalon-MM slave
  input  wire [13:0] i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  // Watchdog results
  output reg         o_wdt_reset,
  output reg         o_window_violation,
  output reg         o_window_open
);

  // --------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------
  // Step of 2^(18-code) per tick, so one period is 2^(5+code) ticks;
  // codes above the largest act as the shortest period
  function [`WWD_CNT_WIDTH-1:0] ps_step;
    input [4:0] code;
    begin
      if (code > `WWD_PS_MAX_CODE) begin
        ps_step = 23'h040000;
      end else begin
        ps_step = 23'h040000 >> code;
      end
    end
  endfunction

  function win_closed;
    input [4:0] wcnt;
    input [2:0] code;
    begin
      win_closed = ({1'b0, wcnt} < {1'b0, (3'h7 - code), 2'b00});
    end
  endfunction

  // Aligned word access at the given register index
  function reg_hit;
    input [13:0] addr;
    input [11:0] idx;
    begin
      reg_hit = (addr[1:0] == 2'b00) && (addr[13:2] == idx);
    end
  endfunction

  // A factory field of all ones leaves the field to software
  function cfg_free3;
    input [2:0] cfg;
    begin
      cfg_free3 = (cfg == `WWD_CFG_ALL_ONES_3);
    end
  endfunction

  // --------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------
  // Reset asserts at once and lets go two edges later, on the clock
  reg        rst_meta_n;
  reg        rst_n;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  reg                       cfg_loaded;
  reg  [4:0]                prescale_select;
  reg  [2:0]                clock_select;
  reg  [2:0]                window_size;
  reg                       ps_writable;
  reg                       cs_writable;
  reg                       win_writable;
  reg  [`WWD_CNT_WIDTH-1:0] wdt_count;
  reg                       armed;

  wire [`WWD_IDX_WIDTH-1:0] reg_index;
  wire                      addr_aligned;
  wire                      bus_req;
  wire                      bus_accept;
  wire                      wr_now;
  wire                      rd_now;
  wire                      wr_lane0;
  wire [4:0]                window_counter;
  wire [`WWD_PS_WIDTH-1:0]  prescale_count;
  wire                      osc_tick;
  wire                      closed_now;
  wire                      windowed;
  wire                      ctrl_write;
  wire                      clear_valid;
  wire                      clear_bad;
  wire [`WWD_CNT_WIDTH:0]   count_sum;
  wire                      hit_ps_ctrl;
  wire                      hit_cw_ctrl;
  wire                      timeout_now;
  wire                      bus_take;

  reg  [7:0]                next_rdata;

  assign reg_index    = i_avs_address[13:2];
  assign addr_aligned = (i_avs_address[1:0] == 2'b00);
  assign bus_req      = i_avs_read | i_avs_write;
  assign bus_accept   = bus_req & ~o_avs_waitrequest;
  assign wr_now       = i_avs_write & ~o_avs_waitrequest & addr_aligned;
  assign rd_now       = i_avs_read & ~o_avs_waitrequest & addr_aligned;
  assign wr_lane0     = wr_now & i_avs_byteenable[0];

  // The three count bytes are not latched together and may tear while
  // the count runs: they are meant for debug reads only
  assign prescale_count = wdt_count[`WWD_PS_WIDTH-1:0];
  assign window_counter = wdt_count[`WWD_CNT_WIDTH-1:`WWD_PS_WIDTH];

  // Reserved clock codes select no source, so the count stands still
  assign osc_tick =
    (clock_select == `WWD_CLK_LFOSC) ? i_low_freq_osc_tick :
    (clock_select == `WWD_CLK_MFOSC) ? i_med_freq_osc_tick :
    1'b0;

  assign windowed   = (window_size != `WWD_WIN_FULL_OPEN);
  assign closed_now = windowed &
                      win_closed(window_counter, window_size);

  assign hit_ps_ctrl = reg_hit(i_avs_address, `WWD_IDX_TIMEOUT_CTRL);
  assign hit_cw_ctrl = reg_hit(i_avs_address, `WWD_IDX_CLK_WIN_CTRL);

  // Writes to either control register restart the period
  assign ctrl_write = wr_lane0 & (hit_ps_ctrl | hit_cw_ctrl);

  // Unarmed or early clears are violations in windowed mode
  assign clear_bad   = i_wdt_enable & i_watchdog_clear_instr & cfg_loaded &
                       windowed & (~armed | closed_now);
  assign clear_valid = i_wdt_enable & i_watchdog_clear_instr & cfg_loaded &
                       ~clear_bad;

  assign count_sum = {1'b0, wdt_count} + {1'b0, ps_step(prescale_select)};

  // A carry out of the count is the time-out; restarts take priority
  assign timeout_now = osc_tick & count_sum[`WWD_CNT_WIDTH] &
                       i_wdt_enable & cfg_loaded & ~ctrl_write &
                       ~clear_bad & ~clear_valid;

  // --------------------------------------------------------------
  // Factory configuration and control fields
  // --------------------------------------------------------------
  // Straps are caught on the first edge after release, not in reset
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_loaded      <= 1'b0;
      prescale_select <= `WWD_PS_DEFAULT;
      clock_select    <= `WWD_CLK_DEFAULT;
      window_size     <= `WWD_WIN_FULL_OPEN;
      ps_writable     <= 1'b0;
      cs_writable     <= 1'b0;
      win_writable    <= 1'b0;
    end else if (!cfg_loaded) begin
      cfg_loaded <= 1'b1;
      if (i_factory_timeout_cfg == `WWD_CFG_ALL_ONES_5) begin
        prescale_select <= `WWD_PS_DEFAULT;
        ps_writable     <= 1'b1;
      end else begin
        prescale_select <= i_factory_timeout_cfg;
        ps_writable     <= 1'b0;
      end
      if (cfg_free3(i_factory_clock_cfg)) begin
        clock_select <= `WWD_CLK_DEFAULT;
        cs_writable  <= 1'b1;
      end else begin
        clock_select <= i_factory_clock_cfg;
        cs_writable  <= 1'b0;
      end
      window_size  <= i_factory_window_cfg;
      win_writable <= cfg_free3(i_factory_window_cfg);
    end else begin
      if (wr_lane0 && reg_index == `WWD_IDX_TIMEOUT_CTRL &&
          ps_writable) begin
        prescale_select <=
          i_avs_writedata[`WWD_PS_SEL_MSB:`WWD_PS_SEL_LSB];
      end
      if (wr_lane0 && reg_index == `WWD_IDX_CLK_WIN_CTRL) begin
        if (cs_writable) begin
          clock_select <=
            i_avs_writedata[`WWD_CLK_SEL_MSB:`WWD_CLK_SEL_LSB];
        end
        if (win_writable) begin
          window_size <= i_avs_writedata[`WWD_WIN_MSB:`WWD_WIN_LSB];
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Arming
  // --------------------------------------------------------------
  // An arming read in the clear's own cycle arms the next clear
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (!i_wdt_enable || !cfg_loaded) begin
      armed <= 1'b0;
    end else if (rd_now && hit_ps_ctrl) begin
      armed <= 1'b1;
    end else if (clear_valid || clear_bad) begin
      armed <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Prescale and window counter
  // --------------------------------------------------------------
  // Any clear, good or bad, and any control write restart the period
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdt_count <= {`WWD_CNT_WIDTH{1'b0}};
    end else if (!i_wdt_enable || !cfg_loaded) begin
      wdt_count <= {`WWD_CNT_WIDTH{1'b0}};
    end else if (clear_bad || clear_valid || ctrl_write) begin
      wdt_count <= {`WWD_CNT_WIDTH{1'b0}};
    end else if (osc_tick) begin
      wdt_count <= count_sum[`WWD_CNT_WIDTH-1:0];
    end
  end

  // --------------------------------------------------------------
  // Watchdog results
  // --------------------------------------------------------------
  // Registered so that reset and violation are clean one-cycle pulses and window open is a clean level
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_wdt_reset        <= 1'b0;
      o_window_violation <= 1'b0;
      o_window_open      <= 1'b0;
    end else begin
      o_wdt_reset        <= clear_bad | timeout_now;
      o_window_violation <= clear_bad;
      o_window_open      <= ~closed_now;
    end
  end

  // --------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------
  always @* begin
    next_rdata = 8'h00;
    case (reg_index)
      `WWD_IDX_TIMEOUT_CTRL: begin
        next_rdata[`WWD_PS_SEL_MSB:`WWD_PS_SEL_LSB] = prescale_select;
      end
      `WWD_IDX_CLK_WIN_CTRL: begin
        next_rdata[`WWD_CLK_SEL_MSB:`WWD_CLK_SEL_LSB] = clock_select;
        next_rdata[`WWD_WIN_MSB:`WWD_WIN_LSB]         = window_size;
      end
      `WWD_IDX_PS_LOW: begin
        next_rdata = prescale_count[7:0];
      end
      `WWD_IDX_PS_HIGH: begin
        next_rdata = prescale_count[15:8];
      end
      `WWD_IDX_WIN_STATUS: begin
        next_rdata = {window_counter, armed,
                      prescale_count[17:16]};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
    // Unaligned addresses read as zero, like unmapped ones
    if (!addr_aligned) begin
      next_rdata = 8'h00;
    end
  end

  // --------------------------------------------------------------
  // Avalon-MM handshake
  // --------------------------------------------------------------
  // Fixed one wait state: waitrequest drops for one cycle per request
  assign bus_take = bus_req & o_avs_waitrequest & cfg_loaded;

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~bus_take;
    end
  end

  // Read data is caught a cycle early so it stands in the ack cycle;
  // a write clears it so stale data never rides on a later ack
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (bus_take) begin
      o_avs_readdata <= {24'h000000, next_rdata};
    end else if (bus_accept && !i_avs_read) begin
      o_avs_readdata <= 32'h00000000;
    end
  end

endmodule

/* sim/wwd_window_regs_properties.sv */
// Assertion checker for the window watchdog register block
`timescale 1ns/10ps
`include "wwd_regs.vh"
module wwd_window_regs_props (
  // Clock and reset
  input wire        i_clk_sys,
  input wire        i_rst_n,
  // Watchdog inputs
  input wire        i_low_freq_osc_tick,
  input wire        i_med_freq_osc_tick,
  input wire        i_wdt_enable,
  input wire        i_watchdog_clear_instr,
  // Register bus
  input wire [13:0] i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_readdata,
  input wire        o_avs_waitrequest,
  // Watchdog results
  input wire        o_wdt_reset,
  input wire        o_window_violation,
  input wire        o_window_open
);
  wire        req  = i_avs_read | i_avs_write;
  wire        tick = i_low_freq_osc_tick | i_med_freq_osc_tick;
  wire        clr  = i_watchdog_clear_instr & i_wdt_enable;
  wire [11:0] idx  = i_avs_address[13:2];
  wire        rdok = i_avs_read & ~o_avs_waitrequest;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_taken; req && o_avs_waitrequest; endsequence
  sequence s_done; !o_avs_waitrequest ##1 o_avs_waitrequest; endsequence
  a_one_wait: assert property (s_taken |=> s_done)
    else $error("waitrequest not low for one cycle");
  a_ack_cause: assert property ($fell(o_avs_waitrequest)
    |-> $past(req))
    else $error("waitrequest low without request");
  a_rd_upper: assert property (!o_avs_waitrequest
    |-> i_avs_readdata[31:8] == 24'h0)
    else $error("readdata upper bits not zero");
  a_tmr_idle: assert property (rdok && idx == `WWD_IDX_WIN_STATUS
    && !i_wdt_enable && !$past(i_wdt_enable) && !$past(i_wdt_enable, 2)
    |-> i_avs_readdata[7:0] == 8'h00)
    else $error("timer register not zero while idle");
  a_ps_idle: assert property (rdok && !i_wdt_enable
    && (idx == `WWD_IDX_PS_LOW || idx == `WWD_IDX_PS_HIGH)
    && !$past(i_wdt_enable) && !$past(i_wdt_enable, 2)
    |-> i_avs_readdata[7:0] == 8'h00)
    else $error("prescale byte not zero while idle");
  a_closed_clr: assert property (clr && !o_window_open && !tick
    && !$past(tick) && !$past(i_avs_write) |=> o_window_violation)
    else $error("clear in closed window not flagged");
  a_viol_rst: assert property (o_window_violation |-> o_wdt_reset)
    else $error("violation without watchdog reset");
  a_viol_cause: assert property (o_window_violation |-> $past(clr))
    else $error("violation without clear");
  a_rst_pulse: assert property (o_wdt_reset |=> !o_wdt_reset)
    else $error("watchdog reset longer than one cycle");
  a_tmo_tick: assert property (o_wdt_reset && !o_window_violation
    |-> $past(tick))
    else $error("timeout without oscillator tick");
endmodule
bind wwd_window_regs wwd_window_regs_props u_props (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_low_freq_osc_tick(i_low_freq_osc_tick),
  .i_med_freq_osc_tick(i_med_freq_osc_tick), .i_wdt_enable(i_wdt_enable),
  .i_watchdog_clear_instr(i_watchdog_clear_instr),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_wdt_reset(o_wdt_reset),
  .o_window_violation(o_window_violation), .o_window_open(o_window_open));

/* sim/wwd_window_regs_tb_top.sv */
// Self-checking bench for the window watchdog register block
`timescale 1ns/10ps
`include "wwd_regs.vh"
module wwd_window_regs_tb_top;
  logic        clk, rst_n, lt, mt, en, clr, rd, wr, wreq, wrst, viol, wopen;
  logic [4:0]  ftc;
  logic [2:0]  fcc, fwc;
  logic [13:0] adr;
  logic [31:0] wd, rdata;
  logic [7:0]  v;
  int          num_errors, check_count, n_rst, n_viol, n0, i;
  wwd_window_regs DUT (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_factory_timeout_cfg(ftc), .i_factory_clock_cfg(fcc),
    .i_factory_window_cfg(fwc), .i_low_freq_osc_tick(lt),
    .i_med_freq_osc_tick(mt), .i_wdt_enable(en),
    .i_watchdog_clear_instr(clr), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h1),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_wdt_reset(wrst),
    .o_window_violation(viol), .o_window_open(wopen));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Pulse counters, so late pulses are not missed by a single sample
  always @(posedge clk) begin
    if (wrst === 1'b1) n_rst++;
    if (viol === 1'b1) n_viol++;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    rd <= !w; wr <= w; adr <= {a, 2'b00}; wd <= {24'h0, d};
    do begin @(posedge clk); n++; end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    v = rdata[7:0];
    rd <= 0; wr <= 0;
    @(posedge clk);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] e);
    acc(0, a, 8'h00);
    chk(nm, e, v);
  endtask
  // Requests and enable start only once the factory fields are loaded
  task automatic rst(input logic [4:0] t, input logic [2:0] c,
                     input logic [2:0] w, input logic e);
    rst_n <= 0; en <= 0; ftc <= t; fcc <= c; fwc <= w;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    en <= e;
  endtask
  task automatic tk(input logic m, input int k);
    repeat (k) begin
      lt <= !m; mt <= m;
      @(posedge clk);
      lt <= 0; mt <= 0;
      @(posedge clk);
    end
  endtask
  task automatic clear;
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    repeat (3) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("Checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    stop_test;
  end
  initial begin
    {lt, mt, clr, rd, wr} = 0;
    adr = 0;
    wd = 0;
    rst(5'h1f, 3'h7, 3'h7, 1'b0);
    rdc("ps_sel", `WWD_IDX_TIMEOUT_CTRL, 8'h16);
    rdc("clk_win", `WWD_IDX_CLK_WIN_CTRL, 8'h07);
    rdc("unmapped", 12'h000, 8'h00);
    for (i = 4; i < 7; i++) begin
      acc(1, 12'(12'hed0 + i), 8'hff);
      rdc("ro_reg", 12'(12'hed0 + i), 8'h00);
    end
    acc(1, `WWD_IDX_TIMEOUT_CTRL, 8'h22);
    rdc("ps_wr", `WWD_IDX_TIMEOUT_CTRL, 8'h22);
    acc(1, `WWD_IDX_CLK_WIN_CTRL, 8'h17);
    rdc("cw_wr", `WWD_IDX_CLK_WIN_CTRL, 8'h17);
    en <= 1;
    tk(0, 1);
    rdc("lf_gated", `WWD_IDX_PS_LOW, 8'h00);
    tk(1, 1);
    rdc("mf_tick", `WWD_IDX_PS_LOW, 8'h02);
    tk(1, 128);
    rdc("ps_high", `WWD_IDX_PS_HIGH, 8'h01);
    // Reserved clock code: neither oscillator may move the count
    acc(1, `WWD_IDX_CLK_WIN_CTRL, 8'h27);
    tk(1, 1);
    tk(0, 1);
    rdc("rsv_clk", `WWD_IDX_PS_LOW, 8'h00);
    rst(5'h05, 3'h1, 3'h3, 1'b1);
    acc(1, `WWD_IDX_TIMEOUT_CTRL, 8'h3e);
    acc(1, `WWD_IDX_CLK_WIN_CTRL, 8'h77);
    rdc("ps_fixed", `WWD_IDX_TIMEOUT_CTRL, 8'h0a);
    rdc("cw_fixed", `WWD_IDX_CLK_WIN_CTRL, 8'h13);
    // Last closed count of window codes 0 to 6, armed clear still refused
    for (i = 0; i < 7; i++) begin
      rst(5'h00, 3'h0, 3'(i), 1'b1);
      tk(0, 27 - 4 * i);
      acc(0, `WWD_IDX_TIMEOUT_CTRL, 8'h00);
      rdc("tmr", `WWD_IDX_WIN_STATUS, {5'(27 - 4 * i), 3'b100});
      n0 = n_viol;
      clear;
      chk("closed", 8'(n0 + 1), 8'(n_viol));
    end
    rst(5'h00, 3'h0, 3'h6, 1'b1);
    tk(0, 5);
    n0 = n_viol;
    clear;
    chk("unarmed", 8'(n0 + 1), 8'(n_viol));
    rst(5'h00, 3'h0, 3'h6, 1'b1);
    tk(0, 4);
    acc(0, `WWD_IDX_TIMEOUT_CTRL, 8'h00);
    chk("open", 8'h01, {7'h0, wopen});
    n0 = n_viol;
    clear;
    chk("armed_ok", 8'(n0), 8'(n_viol));
    rdc("cleared", `WWD_IDX_WIN_STATUS, 8'h00);
    n0 = n_rst;
    tk(0, 31);
    chk("no_tmo", 8'(n0), 8'(n_rst));
    tk(0, 1);
    repeat (2) @(posedge clk);
    chk("tmo", 8'(n0 + 1), 8'(n_rst));
    stop_test;
  end
endmodule
